// >>> dv/dmbi_link_properties.sv
// checker: properties of the mask/invert link between the two ends
`timescale 1ns/1ps
module dmbi_link_props (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_io_config_mode_reg,
    input wire logic [7:0] i_misc_control_mode_reg,
    input wire logic [2:0] cmd,
    input wire logic cmd_vld,
    input wire logic beat_vld,
    input wire logic [dmbi_pkg::LANES-1:0] mi_h,
    input wire logic [dmbi_pkg::LANES-1:0] mi_h_oe_n,
    input wire logic [dmbi_pkg::DQ_W-1:0] dq_d,
    input wire logic [dmbi_pkg::LANES-1:0] mi_d,
    input wire logic [dmbi_pkg::LANES-1:0] mi_d_oe_n,
    input wire logic [dmbi_pkg::LANES-1:0] mi_d_rx_en
);
    import dmbi_pkg::*;
    logic [2:0] cur_q;
    logic wi;
    logic ri;
    logic mk;
    // mode enables; the bench moves them only while the link is idle
    assign wi = i_io_config_mode_reg[WR_INV_BIT];
    assign ri = i_io_config_mode_reg[RD_INV_BIT];
    assign mk = i_misc_control_mode_reg[WMASK_BIT];
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);
    // command that the following beats belong to
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cur_q <= 3'h0;
        end else if (cmd_vld) begin
            cur_q <= cmd;
        end
    end
    a_rd_dbi_ones: assert property (beat_vld && cur_q == DMBI_CMD_RD && ri |=>
        !mi_d_oe_n && $countones(dq_d[7:0]) <= 4 && $countones(dq_d[15:8]) <= 4)
        else $error("read byte sent with more than four ones");
    a_rd_drv_off: assert property (beat_vld && cur_q == DMBI_CMD_RD && !ri |=>
        &mi_d_oe_n) else $error("pin driven on read without inversion");
    a_mrr_pin_low: assert property (beat_vld && cur_q == DMBI_CMD_MRR && ri |=>
        mi_d == 2'h0) else $error("pin not low on mode readback");
    a_rx_off_wr: assert property (beat_vld && cur_q == DMBI_CMD_WR && !wi |->
        mi_d_rx_en == 2'h0) else $error("receiver on with no pin function");
    a_rx_on_wr: assert property (beat_vld && cur_q == DMBI_CMD_WR && wi |->
        mi_d_rx_en == 2'h3) else $error("receiver off on inverted write");
    a_plain_wr_low: assert property (beat_vld && cur_q == DMBI_CMD_WR && !wi |->
        mi_h == 2'h0) else $error("pin not low on plain write");
    a_mw_inv_low: assert property (beat_vld && cur_q == DMBI_CMD_MWR && wi |->
        mi_h == 2'h0) else $error("pin not low on inverted masked write");
    a_one_driver: assert property ((~mi_d_oe_n & ~mi_h_oe_n) == 2'h0)
        else $error("both ends drive the pin");
    a_no_mwr_off: assert property (cmd_vld && !mk |-> cmd != DMBI_CMD_MWR)
        else $error("masked write sent while masking is off");
    a_train_idle: assert property (beat_vld && !(wi || ri || mk) &&
        (cur_q == DMBI_CMD_FRD || cur_q == DMBI_CMD_RDT) |=> &mi_d_oe_n)
        else $error("pin driven in training with all off");
    c_rd_inv: cover property (beat_vld && cur_q == DMBI_CMD_RD && ri);
    c_mwr: cover property (beat_vld && cur_q == DMBI_CMD_MWR);
    c_fifo_rd: cover property (beat_vld && cur_q == DMBI_CMD_FRD);
endmodule : dmbi_link_props

// >>> dv/dram_data_mask_bus_inversion_tb.sv
// testbench: both link ends back to back, driven from their user sides
`timescale 1ns/1ps
module dram_data_mask_bus_inversion_tb;
    import dmbi_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] io_cfg = 8'h00;
    logic [7:0] misc = 8'h00;
    logic [15:0] rd_data = 16'h0000;
    logic [15:0] hwd = 16'h0000;
    logic [2:0] hcmd = 3'h0;
    logic hcv = 1'b0;
    logic hbv = 1'b0;
    logic [1:0] hwm = 2'h0;
    logic [1:0] hpat = 2'h0;
    logic [1:0] rd_pat = 2'h0;
    logic [15:0] wr_data, rd_dout, wd, dd;
    logic [1:0] wr_keep, rd_pin, wk, md, mo, rx;
    logic wr_vld, illegal, refused;
    logic bv_q = 1'b0;
    int nw = 0;
    int nref = 0;
    int nill = 0;
    int n_fail = 0;
    int cmp_count = 0;
    int cyc = 0;
    dmbi_if lnk ();
    dmbi_host u_dmbi_host (.i_core_clk(clk), .i_sys_rst(rst),
        .i_wr_inv_en(io_cfg[WR_INV_BIT]), .i_rd_inv_en(io_cfg[RD_INV_BIT]),
        .i_wmask_en(misc[WMASK_BIT]), .i_cmd_vld(hcv), .i_cmd(hcmd), .i_beat_vld(hbv),
        .i_wr_data(hwd), .i_wr_mask(hwm), .i_train_pat(hpat), .o_cmd_refused(refused),
        .o_rd_data(rd_dout), .o_rd_pin(rd_pin), .lnk(lnk));
    dmbi_device u_dmbi_device (.i_core_clk(clk), .i_sys_rst(rst),
        .i_io_config_mode_reg(io_cfg), .i_misc_control_mode_reg(misc),
        .i_rd_data(rd_data), .i_rd_train_pat(rd_pat), .o_wr_data(wr_data),
        .o_wr_keep(wr_keep), .o_wr_vld(wr_vld), .o_illegal_cmd(illegal), .lnk(lnk));
    dmbi_link_props u_dmbi_link_props (.i_core_clk(clk), .i_sys_rst(rst),
        .i_io_config_mode_reg(io_cfg), .i_misc_control_mode_reg(misc), .cmd(lnk.cmd),
        .cmd_vld(lnk.cmd_vld), .beat_vld(lnk.beat_vld), .mi_h(lnk.mi_h),
        .mi_h_oe_n(lnk.mi_h_oe_n), .dq_d(lnk.dq_d), .mi_d(lnk.mi_d),
        .mi_d_oe_n(lnk.mi_d_oe_n), .mi_d_rx_en(lnk.mi_d_rx_en));
    // 200 MHz core clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // capture the device's answer one cycle after each link beat
    always @(posedge clk) begin
        bv_q <= lnk.beat_vld;
        if (lnk.beat_vld) begin
            rx <= lnk.mi_d_rx_en;
        end
        if (bv_q) begin
            dd <= lnk.dq_d;
            md <= lnk.mi_d;
            mo <= lnk.mi_d_oe_n;
        end
        if (wr_vld) begin
            wd <= wr_data;
            wk <= wr_keep;
        end
        nw <= nw + int'(wr_vld);
        nref <= nref + int'(refused);
        nill <= nill + int'(illegal);
    end
    // cut a hang short well past the expected 130 or so cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : cmp
    // modes change only while idle; the mask enable is retimed inside
    task automatic set_mode(input logic w, input logic r, input logic m);
        io_cfg = {w, r, 6'h00};
        misc = {2'h0, m, 5'h00};
        repeat (3) @(posedge clk);
        #1;
    endtask : set_mode
    // one command with a single beat, latencies as handed over
    task automatic xfer(input logic [2:0] c, input logic [15:0] d, input logic [1:0] m);
        hcmd = c;
        hcv = 1'b1;
        hwd = d;
        hwm = m;
        @(posedge clk) #1 hcv = 1'b0;
        @(posedge clk) #1 hbv = 1'b1;
        @(posedge clk) #1 hbv = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask : xfer
    task automatic t_write();
        set_mode(1'b1, 1'b0, 1'b0);
        xfer(DMBI_CMD_WR, 16'hfe07, 2'h1);
        cmp(wd, 16'hfef8, "inverted write data");
        cmp(rx, 2'h3, "receiver state");
        set_mode(1'b0, 1'b0, 1'b1);
        xfer(DMBI_CMD_WR, 16'h1234, 2'h3);
        cmp({wk, wd[13:0]}, {2'h3, 14'h1234}, "plain write masked");
        cmp(rx, 2'h0, "receiver left on");
    endtask : t_write
    task automatic t_read();
        set_mode(1'b0, 1'b1, 1'b0);
        rd_data = 16'h0f1f;
        xfer(DMBI_CMD_RD, 16'h0000, 2'h0);
        cmp(dd, 16'h0fe0, "read wire data");
        cmp(md, 2'h1, "read pin");
        cmp(rd_dout, 16'h0f1f, "read decode");
        set_mode(1'b0, 1'b0, 1'b0);
        xfer(DMBI_CMD_RD, 16'h0000, 2'h0);
        cmp(mo, 2'h3, "driver on without inversion");
        set_mode(1'b0, 1'b1, 1'b0);
        rd_data = 16'hffff;
        xfer(DMBI_CMD_MRR, 16'h0000, 2'h0);
        cmp({md, dd[13:0]}, {2'h0, 14'h3fff}, "mode readback");
    endtask : t_read
    task automatic t_masked();
        int w0;
        int r0;
        int i0;
        set_mode(1'b0, 1'b0, 1'b1);
        xfer(DMBI_CMD_MWR, 16'h5aa5, 2'h2);
        cmp({wk, 6'h00, wd[7:0]}, {2'h1, 6'h00, 8'ha5}, "mask by pin");
        set_mode(1'b1, 1'b0, 1'b1);
        xfer(DMBI_CMD_MWR, 16'h3f7c, 2'h0);
        cmp({wk, 6'h00, wd[15:8]}, {2'h2, 6'h00, 8'h3f}, "mask by ones");
        set_mode(1'b1, 1'b0, 1'b0);
        w0 = nw;
        r0 = nref;
        i0 = nill;
        xfer(DMBI_CMD_MWR, 16'h0000, 2'h1);
        cmp(16'(nref - r0), 16'h0001, "masked write not refused");
        cmp(16'(nw - w0), 16'h0000, "write with masking off");
        cmp(16'(nill - i0), 16'h0000, "refused command reached the device");
    endtask : t_masked
    task automatic t_train();
        int w0;
        set_mode(1'b0, 1'b0, 1'b1);
        hpat = 2'h2;
        rd_pat = 2'h1;
        w0 = nw;
        xfer(DMBI_CMD_FWR, 16'h00ff, 2'h0);
        cmp(16'(nw - w0), 16'h0000, "fifo write reached the array");
        xfer(DMBI_CMD_FRD, 16'h0000, 2'h0);
        cmp({md, rd_pin}, {2'h2, 2'h2}, "fifo pin pattern");
        xfer(DMBI_CMD_RDT, 16'h0000, 2'h0);
        cmp({mo, md}, {2'h0, 2'h1}, "training pin pattern");
        set_mode(1'b0, 1'b0, 1'b0);
        xfer(DMBI_CMD_RDT, 16'h0000, 2'h0);
        cmp(mo, 2'h3, "training pin driven");
    endtask : t_train
    // main sequence: reset for 16 cycles, then the scenarios
    initial begin
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        t_write();
        t_read();
        t_masked();
        t_train();
        close_out();
    end
endmodule : dram_data_mask_bus_inversion_tb

// >>> verilog/dmbi_device.sv
// device end: write masking and bus inversion on each byte lane
`timescale 1ns/1ps
module dmbi_device (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_io_config_mode_reg,
    input wire logic [7:0] i_misc_control_mode_reg,
    input wire logic [dmbi_pkg::DQ_W-1:0] i_rd_data,
    input wire logic [dmbi_pkg::LANES-1:0] i_rd_train_pat,
    output logic [dmbi_pkg::DQ_W-1:0] o_wr_data,
    output logic [dmbi_pkg::LANES-1:0] o_wr_keep,
    output logic o_wr_vld,
    output logic o_illegal_cmd,
    dmbi_if.device lnk
);
    import dmbi_pkg::*;

    logic [7:0] io_cfg_q;
    logic [7:0] misc_q;
    dmbi_cmd_e cmd_q;
    logic [BEAT_W-1:0] beat_q;
    logic [LANES-1:0] fifo_q [BEATS];
    logic [DQ_W-1:0] dq_d_q;
    logic [LANES-1:0] mi_d_q;
    logic [DQ_W-1:0] wr_data_q;
    logic [LANES-1:0] wr_keep_q;
    logic wr_vld_q;
    logic illegal_q;
    logic wr_inv, rd_inv, wmask, any_fn;

    // count ones in a field; used by both read inversion and mask decode
    function automatic logic [3:0] ones(input logic [7:0] v, input int unsigned lo);
        logic [3:0] n;
        n = 4'h0;
        for (int unsigned k = 0; k < 8; k++) begin
            if (k >= lo) begin
                n = n + {3'h0, v[k]};
            end
        end
        return n;
    endfunction : ones

    assign wr_inv = io_cfg_q[WR_INV_BIT];
    assign rd_inv = io_cfg_q[RD_INV_BIT];
    assign wmask = misc_q[WMASK_BIT];
    assign any_fn = wr_inv | rd_inv | wmask;

    // mode bits are retimed once so a change never splits a beat
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            io_cfg_q <= MODE_RST;
            misc_q <= MODE_RST;
        end else begin
            io_cfg_q <= i_io_config_mode_reg;
            misc_q <= i_misc_control_mode_reg;
        end
    end

    // command latch and beat counter
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cmd_q <= DMBI_CMD_NONE;
            beat_q <= '0;
        end else if (lnk.cmd_vld) begin
            cmd_q <= dmbi_cmd_e'(lnk.cmd);
            beat_q <= '0;
        end else if (lnk.beat_vld) begin
            beat_q <= beat_q + 4'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= lnk.cmd_vld && dmbi_cmd_e'(lnk.cmd) == DMBI_CMD_MWR && !wmask;
        end
    end

    // receiver enable: pin used only on writes with a function
    always_comb begin
        case (cmd_q)
            DMBI_CMD_WR: lnk.mi_d_rx_en = {LANES{wr_inv}};
            DMBI_CMD_MWR: lnk.mi_d_rx_en = {LANES{wmask}};
            DMBI_CMD_FWR: lnk.mi_d_rx_en = {LANES{any_fn}};
            default: lnk.mi_d_rx_en = '0;
        endcase
    end

    // one pin per lane, sampled together with its byte
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_wr
            logic [7:0] b;
            logic m;
            logic inv;
            logic msk;
            assign b = lnk.dq_h[l*BYTE_W +: BYTE_W];
            assign m = lnk.mi_h[l] & lnk.mi_d_rx_en[l];
            always_comb begin
                inv = 1'b0;
                msk = 1'b0;
                case (cmd_q)
                    DMBI_CMD_WR: inv = wr_inv & m;
                    DMBI_CMD_MWR: begin
                        if (!wr_inv) begin
                            msk = m;
                        end else begin
                            msk = !m && ones(b, 2) >= MW_MASK_ONES;
                            inv = m;
                        end
                    end
                    default: inv = 1'b0;
                endcase
            end
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    wr_data_q[l*BYTE_W +: BYTE_W] <= '0;
                    wr_keep_q[l] <= 1'b0;
                end else if (lnk.beat_vld) begin
                    wr_data_q[l*BYTE_W +: BYTE_W] <= inv ? ~b : b;
                    wr_keep_q[l] <= !msk;
                end
            end
        end
    endgenerate

    // write beat output; fifo training data never reaches the array
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wr_vld_q <= 1'b0;
        end else begin
            wr_vld_q <= lnk.beat_vld && (cmd_q == DMBI_CMD_WR ||
                (cmd_q == DMBI_CMD_MWR && wmask));
        end
    end

    // training fifo captures the pin, data untouched
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < BEATS; i++) begin
                fifo_q[i] <= '0;
            end
        end else if (lnk.beat_vld && cmd_q == DMBI_CMD_FWR && any_fn) begin
            fifo_q[beat_q] <= lnk.mi_h;
        end
    end

    // read side: data and pin registered per beat
    generate
        for (genvar l = 0; l < LANES; l++) begin : g_rd
            logic [7:0] r;
            assign r = i_rd_data[l*BYTE_W +: BYTE_W];
            always_ff @(posedge i_core_clk) begin
                if (i_sys_rst) begin
                    dq_d_q[l*BYTE_W +: BYTE_W] <= '0;
                    mi_d_q[l] <= 1'b0;
                end else if (lnk.beat_vld) begin
                    dq_d_q[l*BYTE_W +: BYTE_W] <= r;
                    mi_d_q[l] <= 1'b0;
                    case (cmd_q)
                        DMBI_CMD_RD: begin
                            if (rd_inv && ones(r, 0) > RD_INV_ONES) begin
                                dq_d_q[l*BYTE_W +: BYTE_W] <= ~r;
                                mi_d_q[l] <= 1'b1;
                            end
                        end
                        DMBI_CMD_FRD: mi_d_q[l] <= fifo_q[beat_q][l];
                        DMBI_CMD_RDT: mi_d_q[l] <= i_rd_train_pat[l];
                        default: mi_d_q[l] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // driver enable per command (low enables)
    always_comb begin
        case (cmd_q)
            DMBI_CMD_RD: lnk.mi_d_oe_n = {LANES{!rd_inv}};
            DMBI_CMD_MRR: lnk.mi_d_oe_n = {LANES{!rd_inv}};
            DMBI_CMD_FRD: lnk.mi_d_oe_n = {LANES{!any_fn}};
            DMBI_CMD_RDT: lnk.mi_d_oe_n = {LANES{!any_fn}};
            default: lnk.mi_d_oe_n = '1;
        endcase
    end

    assign lnk.dq_d = dq_d_q;
    assign lnk.mi_d = mi_d_q;
    assign o_wr_data = wr_data_q;
    assign o_wr_keep = wr_keep_q;
    assign o_wr_vld = wr_vld_q;
    assign o_illegal_cmd = illegal_q;
endmodule : dmbi_device

// >>> verilog/dmbi_host.sv
// controller end: encodes writes with mask/invert and decodes reads
`timescale 1ns/1ps
module dmbi_host (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_wr_inv_en,
    input wire logic i_rd_inv_en,
    input wire logic i_wmask_en,
    input wire logic i_cmd_vld,
    input wire logic [2:0] i_cmd,
    input wire logic i_beat_vld,
    input wire logic [dmbi_pkg::DQ_W-1:0] i_wr_data,
    input wire logic [dmbi_pkg::LANES-1:0] i_wr_mask,
    input wire logic [dmbi_pkg::LANES-1:0] i_train_pat,
    output logic o_cmd_refused,
    output logic [dmbi_pkg::DQ_W-1:0] o_rd_data,
    output logic [dmbi_pkg::LANES-1:0] o_rd_pin,
    dmbi_if.host lnk
);
    import dmbi_pkg::*;

    dmbi_cmd_e cmd_q;
    logic cmd_vld_q, beat_vld_q, refused_q, rd_vld_q;
    logic [DQ_W-1:0] dq_q, rd_q;
    logic [LANES-1:0] mi_q, oe_n_q, rdp_q;
    logic bad;

    // masked write with masking off is never sent
    assign bad = dmbi_cmd_e'(i_cmd) == DMBI_CMD_MWR && !i_wmask_en;

    // command issue and refusal
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cmd_q <= DMBI_CMD_NONE;
            cmd_vld_q <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            cmd_vld_q <= i_cmd_vld && !bad;
            refused_q <= i_cmd_vld && bad;
            if (i_cmd_vld && !bad) begin
                cmd_q <= dmbi_cmd_e'(i_cmd);
            end
        end
    end

    // write beat encoding: pin low unless it carries mask, inversion or the fifo training pattern
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            dq_q <= '0;
            mi_q <= '0;
            oe_n_q <= '1;
            beat_vld_q <= 1'b0;
        end else begin
            beat_vld_q <= i_beat_vld;
            oe_n_q <= (cmd_q == DMBI_CMD_WR || cmd_q == DMBI_CMD_MWR ||
                cmd_q == DMBI_CMD_FWR) ? '0 : '1;
            for (int l = 0; l < LANES; l++) begin
                dq_q[l*BYTE_W +: BYTE_W] <= i_wr_data[l*BYTE_W +: BYTE_W];
                mi_q[l] <= 1'b0;
                case (cmd_q)
                    // pin flags a pre-inverted lane only with inversion on
                    DMBI_CMD_WR: mi_q[l] <= i_wr_mask[l] & i_wr_inv_en;
                    DMBI_CMD_MWR: mi_q[l] <= i_wr_mask[l] & !i_wr_inv_en;
                    DMBI_CMD_FWR: mi_q[l] <= i_train_pat[l];
                    default: mi_q[l] <= 1'b0;
                endcase
            end
        end
    end

    // device answers one cycle after the link beat, so the decode waits a cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rd_vld_q <= 1'b0;
        end else begin
            rd_vld_q <= beat_vld_q;
        end
    end

    // read decode undoes inversion flagged on the pin
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rd_q <= '0;
            rdp_q <= '0;
        end else if (rd_vld_q) begin
            // a lane whose driver is off reads as low
            rdp_q <= lnk.mi_d & ~lnk.mi_d_oe_n;
            for (int l = 0; l < LANES; l++) begin
                rd_q[l*BYTE_W +: BYTE_W] <= (cmd_q == DMBI_CMD_RD && i_rd_inv_en &&
                    !lnk.mi_d_oe_n[l] && lnk.mi_d[l]) ?
                    ~lnk.dq_d[l*BYTE_W +: BYTE_W] : lnk.dq_d[l*BYTE_W +: BYTE_W];
            end
        end
    end

    assign lnk.cmd = cmd_q;
    assign lnk.cmd_vld = cmd_vld_q;
    assign lnk.beat_vld = beat_vld_q;
    assign lnk.dq_h = dq_q;
    assign lnk.mi_h = mi_q;
    assign lnk.mi_h_oe_n = oe_n_q;
    assign o_cmd_refused = refused_q;
    assign o_rd_data = rd_q;
    assign o_rd_pin = rdp_q;
endmodule : dmbi_host

// >>> verilog/dmbi_if.sv
// interface: the data byte lanes with their mask/invert pins
`timescale 1ns/1ps
interface dmbi_if;
    import dmbi_pkg::*;
    logic [2:0] cmd;
    logic cmd_vld;
    logic beat_vld;
    logic [DQ_W-1:0] dq_h;
    logic [LANES-1:0] mi_h;
    logic [LANES-1:0] mi_h_oe_n;
    logic [DQ_W-1:0] dq_d;
    logic [LANES-1:0] mi_d;
    logic [LANES-1:0] mi_d_oe_n;
    logic [LANES-1:0] mi_d_rx_en;
    modport device (input cmd, input cmd_vld, input beat_vld, input dq_h, input mi_h,
        input mi_h_oe_n, output dq_d, output mi_d, output mi_d_oe_n, output mi_d_rx_en);
    modport host (output cmd, output cmd_vld, output beat_vld, output dq_h, output mi_h,
        output mi_h_oe_n, input dq_d, input mi_d, input mi_d_oe_n);
endinterface : dmbi_if

// >>> verilog/dmbi_pkg.sv
// package: constants and types shared by the mask/invert link ends
package dmbi_pkg;
    localparam int unsigned LANES = 2;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned DQ_W = 16;
    localparam int unsigned BEATS = 16;
    localparam int unsigned BEAT_W = 4;
    // operand bit positions in the mode registers
    localparam int unsigned WR_INV_BIT = 7;
    localparam int unsigned RD_INV_BIT = 6;
    localparam int unsigned WMASK_BIT = 5;
    // ones thresholds
    localparam logic [3:0] RD_INV_ONES = 4'h4;
    localparam logic [3:0] MW_MASK_ONES = 4'h5;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [BEAT_W-1:0] BEAT_LAST = 4'hf;
    typedef enum logic [2:0] {
        DMBI_CMD_NONE = 3'b000,
        DMBI_CMD_WR = 3'b001,
        DMBI_CMD_MWR = 3'b010,
        DMBI_CMD_RD = 3'b011,
        DMBI_CMD_FWR = 3'b100,
        DMBI_CMD_FRD = 3'b101,
        DMBI_CMD_RDT = 3'b110,
        DMBI_CMD_MRR = 3'b111
    } dmbi_cmd_e;
endpackage : dmbi_pkg
